// >>> design/epc_regs.sv
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`include "epc_cfg.svh"

// ----------------------------------------
// output buffer
// ----------------------------------------
module epc_fifo #(
	parameter int WIDTH = `EPC_FIFO_WIDTH,
	parameter int DEPTH = `EPC_FIFO_DEPTH
) (
	input wire logic sys_clk, // clock
	input wire logic rst, // sync reset
	input wire logic in_valid, // push request
	output logic in_ready, // room available
	input wire logic [WIDTH-1:0] in_word, // pushed word
	output logic out_valid, // word available
	input wire logic out_ready, // pop request
	output logic [WIDTH-1:0] out_word // head word
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
	} epc_fifo_t;

	epc_fifo_t s;
	epc_fifo_t next_s;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
		ptr_step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	assign in_ready = (s.cnt != CW'(DEPTH));
	assign out_valid = (s.cnt != '0);
	assign out_word = s.mem[s.rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wp] = in_word;
			next_s.wp = ptr_step(s.wp);
		end
		if (pop) begin
			next_s.rp = ptr_step(s.rp);
		end
		next_s.cnt = s.cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule

// Notes on behaviour
// - busy reads 1 while an indirect access is pending, else 0
// - control bit 7: 0 writes data register, 1 reads into it
// - seven-bit address selects 00-3F, 41-4F, 51-5F; others start nothing
// - control write with direction 1 fetches the byte into the data register
// - tx snapshot locks frame-0 signaling for the whole generated multiframe
// - rx snapshot locks frame-0 signaling for the multiframe when in sync
// - global conditioning replaces ABCD of all slots except 0 and 16, else per-slot enable
// - global code 000 uses each slot's own substitution field
// - global code 001 substitutes each slot's data trunk code
// - codes 010 and 011 substitute A-law and mu-law milliwatt patterns
// - tx code 100 substitutes loopback data from the receive store
// - tx enable bit 0 gates all tx functions, reset 0
// - four link copies, link number in address bits above the byte offset
// - rx enable bit 0 gates all rx functions, reset 0
module epc_regs
	import epc_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic rst, // sync reset
	input wire logic [9:0] addr, // link in [9:8], offset in [7:0]
	input wire logic [7:0] wr_data, // write data
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	output logic [7:0] rd_data, // read data, cycle after rd_en
	input wire logic in_valid, // payload word offered
	output logic in_ready, // payload word taken
	input wire logic in_dir, // 0 transmit, 1 receive
	input wire logic [1:0] in_link, // link number
	input wire logic [4:0] in_slot, // timeslot
	input wire logic [3:0] in_frame, // frame within signaling multiframe
	input wire logic in_mf_ok, // signaling multiframe generated / in sync
	input wire logic [7:0] in_data, // timeslot data
	input wire logic [3:0] in_sig, // ABCD bits
	input wire logic [7:0] in_loop, // receive elastic store byte
	output logic out_valid, // processed word ready
	input wire logic out_ready, // consumer accepts
	output logic out_dir, // direction of word
	output logic [1:0] out_link, // link number
	output logic [4:0] out_slot, // timeslot
	output logic [7:0] out_data, // processed data
	output logic [3:0] out_sig // processed ABCD
);
	epc_state_t s;
	epc_state_t next_s;
	logic [7:0] ind_mem [0:7][0:`EPC_IND_SIZE-1];
	logic [3:0] snap_mem [0:7][0:31];

	// ----------------------------------------
	// decode helpers
	// ----------------------------------------
	function automatic epc_kind_t reg_kind(input logic [7:0] off);
		case (off)
			`EPC_OFF_TX_STAT, `EPC_OFF_RX_STAT: reg_kind = EPC_K_STAT;
			`EPC_OFF_TX_CTRL, `EPC_OFF_RX_CTRL: reg_kind = EPC_K_CTRL;
			`EPC_OFF_TX_DATA, `EPC_OFF_RX_DATA: reg_kind = EPC_K_DATA;
			`EPC_OFF_TX_CFG, `EPC_OFF_RX_CFG: reg_kind = EPC_K_CFG;
			`EPC_OFF_TX_EN, `EPC_OFF_RX_EN: reg_kind = EPC_K_EN;
			default: reg_kind = EPC_K_NONE;
		endcase
	endfunction

	function automatic logic [2:0] reg_unit(input logic [9:0] a);
		reg_unit = {(a[7:0] >= `EPC_OFF_RX_STAT), a[9:8]};
	endfunction

	function automatic logic ind_valid(input logic [6:0] a);
		ind_valid = (a <= `EPC_IND_TOP) && (a != `EPC_IND_HOLE0) && (a != `EPC_IND_HOLE1);
	endfunction

	function automatic logic [7:0] pat_byte(input logic [63:0] pat, input logic [2:0] ph);
		pat_byte = pat[63 - 8 * ph -: 8];
	endfunction

	// ----------------------------------------
	// register file and indirect engine
	// ----------------------------------------
	epc_kind_t kind;
	logic [2:0] unit;

	assign kind = reg_kind(addr[7:0]);
	assign unit = reg_unit(addr);

	always_comb begin
		next_s = s;
		next_s.rd_data = 8'h00;
		for (int u = 0; u < 8; u++) begin
			if (s.busy[u]) begin
				next_s.busy[u] = 1'b0;
				if (s.ctrl[u][`EPC_DIR_BIT]) begin
					next_s.data[u] = ind_mem[u][s.ctrl[u][6:0]];
				end
			end
		end
		if (wr_en) begin
			case (kind)
				EPC_K_CTRL: begin
					next_s.ctrl[unit] = wr_data;
					// only mapped indirect addresses start an access
					next_s.busy[unit] = ind_valid(wr_data[6:0]);
				end
				EPC_K_DATA: begin
					next_s.data[unit] = wr_data;
				end
				EPC_K_CFG: begin
					next_s.cfg[unit] = wr_data & `EPC_CFG_MASK;
				end
				EPC_K_EN: begin
					next_s.en[unit] = wr_data[0];
				end
				default: begin
				end
			endcase
		end
		if (rd_en) begin
			case (kind)
				EPC_K_STAT: next_s.rd_data = {7'h00, s.busy[unit]};
				EPC_K_CTRL: next_s.rd_data = s.ctrl[unit];
				EPC_K_DATA: next_s.rd_data = s.data[unit];
				EPC_K_CFG: next_s.rd_data = s.cfg[unit];
				EPC_K_EN: next_s.rd_data = {7'h00, s.en[unit]};
				default: next_s.rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s.ctrl <= {8{`EPC_CTRL_RST}};
			s.data <= {8{`EPC_DATA_RST}};
			s.cfg <= {{4{`EPC_RX_CFG_RST}}, {4{`EPC_TX_CFG_RST}}};
			s.en <= 8'h00;
			s.busy <= 8'h00;
			s.rd_data <= 8'h00;
		end else begin
			s <= next_s;
		end
	end

	assign rd_data = s.rd_data;

	// direction 0 stores the data register
	always_ff @(posedge sys_clk) begin
		for (int u = 0; u < 8; u++) begin
			if (s.busy[u] && !s.ctrl[u][`EPC_DIR_BIT]) begin
				ind_mem[u][s.ctrl[u][6:0]] <= s.data[u];
			end
		end
	end

	// ----------------------------------------
	// payload path
	// ----------------------------------------
	logic [2:0] su;
	logic [7:0] sreg_cfg;
	logic [7:0] slot_sub;
	logic [7:0] slot_trunk;
	logic [7:0] slot_cond;
	logic [2:0] sel;
	logic snap_use;
	logic cond_on;
	logic [7:0] proc_data;
	logic [3:0] proc_sig;
	logic fifo_push_ready;

	// unit picked by direction and link
	assign su = {in_dir, in_link};
	assign sreg_cfg = s.cfg[su];
	assign slot_sub = ind_mem[su][{2'h0, in_slot}];
	assign slot_trunk = ind_mem[su][{`EPC_IND_TRUNK_PAGE, in_slot}];
	assign slot_cond = ind_mem[su][{`EPC_IND_COND_PAGE, in_slot}];
	// snapshot valid only with multiframe present
	assign snap_use = sreg_cfg[`EPC_SNAP_BIT] && in_mf_ok;
	// global or per-slot conditioning, no code for slots 0 and 16
	assign cond_on = (sreg_cfg[`EPC_GCOND_BIT] || slot_cond[`EPC_SLOT_COND_BIT])
		&& (in_slot != `EPC_SLOT_FAS) && (in_slot != `EPC_SLOT_SIG);

	always_comb begin
		// per-slot selection when global code is 000
		sel = (sreg_cfg[2:0] == `EPC_SUB_SLOT) ? slot_sub[7:5] : sreg_cfg[2:0];
		case (sel)
			`EPC_SUB_TRUNK: proc_data = slot_trunk;
			`EPC_SUB_ALAW: proc_data = pat_byte(`EPC_ALAW_PAT, in_frame[2:0]);
			`EPC_SUB_MULAW: proc_data = pat_byte(`EPC_MULAW_PAT, in_frame[2:0]);
			`EPC_SUB_LOOP: proc_data = in_dir ? in_data : in_loop;
			default: proc_data = in_data;
		endcase
		proc_sig = in_sig;
		if (snap_use && (in_frame != 4'h0)) begin
			proc_sig = snap_mem[su][in_slot];
		end
		if (cond_on) begin
			proc_sig = slot_cond[3:0];
		end
		// disabled unit passes the payload untouched
		if (!s.en[su]) begin
			proc_data = in_data;
			proc_sig = in_sig;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (in_valid && fifo_push_ready && snap_use && (in_frame == 4'h0)) begin
			snap_mem[su][in_slot] <= in_sig;
		end
	end

	assign in_ready = fifo_push_ready;

	epc_fifo #(
		.WIDTH(`EPC_FIFO_WIDTH),
		.DEPTH(`EPC_FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(in_valid),
		.in_ready(fifo_push_ready),
		.in_word({in_dir, in_link, in_slot, proc_data, proc_sig}),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_word({out_dir, out_link, out_slot, out_data, out_sig})
	);
endmodule

// >>> inc/epc_cfg.svh
`ifndef EPC_CFG_SVH
`define EPC_CFG_SVH

// ----------------------------------------
// register offsets within one link
// ----------------------------------------
`define EPC_OFF_TX_STAT 8'hc8
`define EPC_OFF_TX_CTRL 8'hc9
`define EPC_OFF_TX_DATA 8'hca
`define EPC_OFF_TX_CFG 8'hcb
`define EPC_OFF_TX_EN 8'hcc
`define EPC_OFF_RX_STAT 8'hcd
`define EPC_OFF_RX_CTRL 8'hce
`define EPC_OFF_RX_DATA 8'hcf
`define EPC_OFF_RX_CFG 8'hd0
`define EPC_OFF_RX_EN 8'hd1

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define EPC_DIR_BIT 7
`define EPC_SNAP_BIT 7
`define EPC_GCOND_BIT 6
`define EPC_CFG_MASK 8'hc7
`define EPC_TX_CFG_RST 8'h80
`define EPC_RX_CFG_RST 8'h00
`define EPC_CTRL_RST 8'h00
`define EPC_DATA_RST 8'h00
`define EPC_SLOT_COND_BIT 4

// ----------------------------------------
// substitution codes
// ----------------------------------------
`define EPC_SUB_SLOT 3'h0
`define EPC_SUB_TRUNK 3'h1
`define EPC_SUB_ALAW 3'h2
`define EPC_SUB_MULAW 3'h3
`define EPC_SUB_LOOP 3'h4

// ----------------------------------------
// indirect map
// ----------------------------------------
`define EPC_IND_TOP 7'h5f
`define EPC_IND_HOLE0 7'h40
`define EPC_IND_HOLE1 7'h50
`define EPC_IND_SIZE 96
`define EPC_IND_TRUNK_PAGE 2'h1
`define EPC_IND_COND_PAGE 2'h2
`define EPC_SLOT_FAS 5'h00
`define EPC_SLOT_SIG 5'h10

// ----------------------------------------
// milliwatt patterns, first byte in the top lane
// ----------------------------------------
`define EPC_ALAW_PAT 64'h34212134b4a1a1b4
`define EPC_MULAW_PAT 64'h1e0b0b1e9e8b8b9e

// ----------------------------------------
// output buffer
// ----------------------------------------
`define EPC_FIFO_DEPTH 4
`define EPC_FIFO_WIDTH 20

`endif

// >>> inc/epc_pkg.sv
package epc_pkg;
	typedef enum {EPC_K_NONE, EPC_K_STAT, EPC_K_CTRL, EPC_K_DATA, EPC_K_CFG, EPC_K_EN} epc_kind_t;

	typedef struct packed {
		logic [7:0][7:0] ctrl;
		logic [7:0][7:0] data;
		logic [7:0][7:0] cfg;
		logic [7:0] en;
		logic [7:0] busy;
		logic [7:0] rd_data;
	} epc_state_t;
endpackage

// >>> testbench/e1_payload_control_regs_test.sv
`timescale 1ns/1ps
`include "epc_cfg.svh"
module e1_payload_control_regs_test;
	logic sys_clk = 0, rst = 1, wr_en = 0, rd_en = 0, in_valid = 0, in_dir = 0, stall = 0;
	logic [9:0] addr = 0;
	logic [7:0] wr_data = 0, in_data = 0, rd_data, out_data, got_d, cnt;
	logic [3:0] in_frame = 0, in_sig = 0, out_sig, got_s;
	logic in_ready, out_valid, out_ready;
	logic out_dir, mf_ok = 1'b1;
	logic [1:0] link = 2'h0, out_link;
	logic [4:0] out_slot;
	logic [7:0] got_h;
	int n_fail = 0, n_compared = 0;
	always #5 sys_clk = ~sys_clk;
	epc_regs dut (.sys_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .in_valid,
		.in_ready, .in_dir, .in_link(link), .in_slot(5'h05), .in_frame, .in_mf_ok(mf_ok),
		.in_data, .in_sig, .in_loop(8'h77), .out_valid, .out_ready, .out_dir, .out_link,
		.out_slot, .out_data, .out_sig);
	epc_sink sink (.sys_clk, .stall, .out_valid, .out_data, .out_sig, .out_dir, .out_link,
		.out_slot, .out_ready, .got_h, .got_d, .got_s, .cnt);
	// ----
	// access tasks
	// ----
	task chk(string n, logic [7:0] e, logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(logic [9:0] a, logic [7:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		rd_en <= 1'b0;
		@(posedge sys_clk);
	endtask
	task idle();
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		in_valid <= 1'b0;
		@(posedge sys_clk);
	endtask
	task rd(logic [9:0] a, logic [7:0] e);
		addr <= a;
		wr_en <= 1'b0;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(posedge sys_clk);
		chk($sformatf("reg %h", a), e, rd_data);
	endtask
	task ind(logic [7:0] a, logic [7:0] d);
		wr(10'h0ca, d);
		wr(10'h0c9, a);
		idle();
	endtask
	task push(logic [3:0] f, logic [3:0] s);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		in_data <= 8'h11;
		in_frame <= f;
		in_sig <= s;
		in_valid <= 1'b1;
		@(posedge sys_clk);
	endtask
	task px(logic [3:0] f, logic [3:0] s, logic [7:0] ed, logic [3:0] es);
		logic [7:0] c;
		c = cnt;
		push(f, s);
		idle();
		for (int i = 0; i < 8 && cnt == c; i++) @(posedge sys_clk);
		chk("words popped", c + 8'h01, cnt);
		chk("head", {in_dir, link, 5'h05}, got_h);
		chk("data", ed, got_d);
		chk("abcd", {4'h0, es}, {4'h0, got_s});
	endtask
	task conclude();
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_fail++;
		conclude();
	end
	// ----
	// tests
	// ----
	initial begin
		logic [7:0] e;
		int c;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		idle();
		rd(10'h0c8, 8'h00);
		rd(10'h0c9, 8'h00);
		rd(10'h0ca, 8'h00);
		rd(10'h0cb, 8'h80);
		rd(10'h0cc, 8'h00);
		rd(10'h0d0, 8'h00);
		rd(10'h0d2, 8'h00);
		wr(10'h0ca, 8'h5a);
		wr(10'h0c9, 8'h25);
		rd(10'h0c8, 8'h01);
		rd(10'h0c8, 8'h00);
		ind(8'h05, 8'h20);
		ind(8'h45, 8'h09);
		rd(10'h0c8, 8'h00);
		ind(8'ha5, 8'h00);
		rd(10'h0ca, 8'h5a);
		wr(10'h0ca, 8'hee);
		wr(10'h0c9, 8'h40);
		rd(10'h0c8, 8'h00);
		ind(8'hc5, 8'h00);
		rd(10'h0ca, 8'h09);
		wr(10'h2cb, 8'hff);
		rd(10'h2cb, 8'hc7);
		rd(10'h0cb, 8'h80);
		rd(10'h3cc, 8'h00);
		wr(10'h0cc, 8'hff);
		rd(10'h0cc, 8'h01);
		for (int k = 0; k < 16; k++) begin
			c = k % 8;
			e = c < 2 ? 8'h5a : c == 4 ? 8'h77 : c > 4 ? 8'h11
				: 8'((c == 2 ? `EPC_ALAW_PAT : `EPC_MULAW_PAT) >> (56 - 8 * (k / 2)));
			wr(10'h0cb, 8'(c));
			idle();
			px(4'(k / 2), 4'h3, e, 4'h3);
		end
		wr(10'h0cb, 8'h41);
		px(4'h2, 4'h3, 8'h5a, 4'h9);
		wr(10'h0cb, 8'h81);
		px(4'h0, 4'h6, 8'h5a, 4'h6);
		px(4'h1, 4'h2, 8'h5a, 4'h6);
		link <= 2'h3;
		px(4'h1, 4'h2, 8'h11, 4'h2);
		link <= 2'h0;
		wr(10'h0cc, 8'h00);
		px(4'h1, 4'h2, 8'h11, 4'h2);
		wr(10'h0cf, 8'h0c);
		wr(10'h0ce, 8'h45);
		idle();
		wr(10'h0cf, 8'h00);
		wr(10'h0ce, 8'hc5);
		idle();
		rd(10'h0cf, 8'h0c);
		in_dir <= 1'b1;
		wr(10'h0d1, 8'h01);
		wr(10'h0d0, 8'h84);
		px(4'h0, 4'h4, 8'h11, 4'h4);
		px(4'h1, 4'h1, 8'h11, 4'h4);
		mf_ok <= 1'b0;
		px(4'h1, 4'h1, 8'h11, 4'h1);
		wr(10'h0d1, 8'h00);
		px(4'h1, 4'h1, 8'h11, 4'h1);
		stall <= 1'b1;
		idle();
		repeat (4) push(4'h0, 4'h0);
		idle();
		chk("room full", 8'h00, {7'h00, in_ready});
		stall <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk("room empty", 8'h01, {7'h00, in_ready});
		conclude();
	end
endmodule

// >>> testbench/epc_regs_monitor.sv
`timescale 1ns/1ps
module epc_regs_monitor (
	input wire logic sys_clk, // clock
	input wire logic rst, // reset
	input wire logic [9:0] addr, // address
	input wire logic [7:0] wr_data, // write data
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	input wire logic [7:0] rd_data, // read data
	input wire logic in_valid, // push
	input wire logic in_ready, // room
	input wire logic out_valid, // word out
	input wire logic out_ready, // pop
	input wire logic [7:0] out_data, // data out
	input wire logic [3:0] out_sig // abcd out
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----
	// indirect access, read data and payload buffer
	// ----
	sequence s_go;
		wr_en && addr[7:0] inside {8'hc9, 8'hce} && !wr_data[6];
	endsequence
	sequence s_bad;
		wr_en && addr[7:0] inside {8'hc9, 8'hce} && wr_data[6:0] == 7'h40;
	endsequence
	a_busy_seen: assert property (
		s_go ##1 rd_en && addr == $past(addr) - 10'h1 |=> rd_data == 8'h01)
		else $error("busy missing after control write");
	a_busy_done: assert property (
		s_go ##1 !wr_en ##1 rd_en && addr == $past(addr, 2) - 10'h1 |=> rd_data == 8'h00)
		else $error("busy still set after transfer");
	a_bad_target: assert property (
		s_bad ##1 rd_en && addr == $past(addr) - 10'h1 |=> rd_data == 8'h00)
		else $error("invalid target started an access");
	a_rd_quiet: assert property (!$past(rd_en) |-> rd_data == 8'h00)
		else $error("read data outside read cycle");
	a_unmapped_zero: assert property (rd_en && addr[7:0] == 8'hd2 |=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	a_enable_bits: assert property (
		rd_en && addr[7:0] inside {8'hcc, 8'hd1} |=> rd_data[7:1] == 7'h00)
		else $error("enable reserved bits set");
	a_cfg_reserved: assert property (
		rd_en && addr[7:0] inside {8'hcb, 8'hd0} |=> rd_data[5:3] == 3'h0)
		else $error("config reserved bits set");
	a_push_show: assert property (in_valid && in_ready && !out_valid |=> out_valid)
		else $error("pushed word not offered");
	a_word_held: assert property (out_valid && !out_ready
		|=> out_valid && $stable(out_data) && $stable(out_sig))
		else $error("offered word changed before pop");
endmodule
bind epc_regs epc_regs_monitor mon (.sys_clk, .rst, .addr, .wr_data, .wr_en, .rd_en,
	.rd_data, .in_valid, .in_ready, .out_valid, .out_ready, .out_data, .out_sig);

// >>> testbench/epc_sink.sv
`timescale 1ns/1ps
module epc_sink (
	input wire logic sys_clk, // clock
	input wire logic stall, // hold off pops
	input wire logic out_valid, // word offered
	input wire logic [7:0] out_data, // offered data
	input wire logic [3:0] out_sig, // offered abcd
	input wire logic out_dir, // offered direction
	input wire logic [1:0] out_link, // offered link
	input wire logic [4:0] out_slot, // offered slot
	output logic out_ready = 1'b0, // pop
	output logic [7:0] got_h = 8'h00, // last direction, link and slot
	output logic [7:0] got_d = 8'h00, // last data
	output logic [3:0] got_s = 4'h0, // last abcd
	output logic [7:0] cnt = 8'h00 // words popped
);
	always @(posedge sys_clk) begin
		out_ready <= !stall;
		if (out_valid && out_ready) begin
			got_d <= out_data;
			got_s <= out_sig;
			got_h <= {out_dir, out_link, out_slot};
			cnt <= cnt + 8'h01;
		end
	end
endmodule
